// [core/bis_regs.svh]
// register offsets, field positions, reset values and time figures of the burner sequencer
// assumes a 20 MHz system clock and a byte-addressed 32-bit register bus
`ifndef BIS_REGS_SVH
`define BIS_REGS_SVH

// byte offsets
`define BIS_CTRL_OFS      4'h0
`define BIS_DEMAND_OFS    4'h4
`define BIS_STATUS_OFS    4'h8
`define BIS_OUTPUTS_OFS   4'hc

// control fields
`define BIS_CTRL_CALL     0
`define BIS_CTRL_STAGED   1
`define BIS_CTRL_SPLIT    2
`define BIS_CTRL_TWOSTG   3
`define BIS_CTRL_RST      4'h0
`define BIS_DEMAND_RST    8'h00

// status fields
`define BIS_ST_STATE_LSB  0
`define BIS_ST_TRIAL_LSB  8
`define BIS_ST_FLAME      10
`define BIS_ST_RESTART    11
`define BIS_ST_OPENPH     12

// timing
`define BIS_CLK_HZ        20000000
`define BIS_TICK_S        1
`define BIS_PURGE_S       30
`define BIS_AIR_OPEN_S    5
`define BIS_IGN_S         10
`define BIS_WARMUP_S      60
`define BIS_POST_PURGE_S  45
`define BIS_LOCKOUT_S     3600
`define BIS_MAX_RUN_S     21600
`define BIS_MAX_TRIALS    3

`endif

// [core/bis_pkg.sv]
// types shared by the burner sequencer modules
// assumes nothing beyond a SystemVerilog compiler
package bis_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_OFF    = 8'h01,
    ST_CHECK  = 8'h02,
    ST_PURGE  = 8'h04,
    ST_IGNITE = 8'h08,
    ST_WARMUP = 8'h10,
    ST_RUN    = 8'h20,
    ST_POST   = 8'h40,
    ST_LOCK   = 8'h80
  } bis_state_e;

  typedef logic [15:0] bis_secs_t;

endpackage

// [core/bis_tmr_if.sv]
// carrier between the sequencer and its seconds timer
// assumes one clock domain shared by both ends
interface bis_tmr_if;
  logic              load;
  bis_pkg::bis_secs_t secs;
  logic              done;

  modport ctl (output load, output secs, input done);
  modport tmr (input load, input secs, output done);
endinterface

// [core/bis_timer.sv]
// seconds countdown timer with its own tick prescaler
// assumes load is a one-cycle request; done is valid the cycle after load
`include "bis_regs.svh"
module bis_timer #(
  parameter int TICK_CYCLES = `BIS_CLK_HZ * `BIS_TICK_S
) (
  input  wire logic clk,
  input  wire logic rstn,
  bis_tmr_if.tmr    t
);
  logic [31:0]        pre_r;
  bis_pkg::bis_secs_t remain_r;
  logic               tick;

  assign tick   = (pre_r == 32'(TICK_CYCLES - 1));
  assign t.done = (remain_r == 16'h0000);

  // prescaler restarts on load so a period is never cut short
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pre_r <= 32'h0000_0000;
    else if (t.load || tick)
      pre_r <= 32'h0000_0000;
    else
      pre_r <= pre_r + 32'h0000_0001;
  end

  // seconds remaining
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      remain_r <= 16'h0000;
    else if (t.load)
      remain_r <= t.secs;
    else if (tick && remain_r != 16'h0000)
      remain_r <= remain_r - 16'h0001;
  end
endmodule

// [core/bis_top.sv]
// burner ignition sequencer: state machine, output drive and Avalon-MM registers
// assumes switch and flame inputs already synchronous to clk; clk is 20 MHz
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`include "bis_regs.svh"
module bis_top #(
  parameter int        TICK_CYCLES  = `BIS_CLK_HZ * `BIS_TICK_S,
  parameter logic [15:0] PURGE_S    = 16'(`BIS_PURGE_S / `BIS_TICK_S),
  parameter logic [15:0] AIR_OPEN_S = 16'(`BIS_AIR_OPEN_S / `BIS_TICK_S),
  parameter logic [15:0] IGN_S      = 16'(`BIS_IGN_S / `BIS_TICK_S),
  parameter logic [15:0] WARMUP_S   = 16'(`BIS_WARMUP_S / `BIS_TICK_S),
  parameter logic [15:0] POST_S     = 16'(`BIS_POST_PURGE_S / `BIS_TICK_S),
  parameter logic [15:0] LOCKOUT_S  = 16'(`BIS_LOCKOUT_S / `BIS_TICK_S),
  parameter logic [15:0] MAX_RUN_S  = 16'(`BIS_MAX_RUN_S / `BIS_TICK_S),
  parameter logic [7:0]  PURGE_SET  = 8'hc0,
  parameter logic [7:0]  LIGHT_IND  = 8'h80,
  parameter logic [7:0]  LIGHT_RATE = 8'h40,
  parameter logic [7:0]  VALVE_SET  = 8'h00,
  parameter logic [7:0]  SEC_THRESH = 8'h80,
  parameter logic [7:0]  HIGH_THRESH = 8'hf0
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        hilimit_closed,
  input  wire logic        rollout_closed,
  input  wire logic        airsw_closed,
  input  wire logic        valve_pos_ok,
  input  wire logic        flame,
  output logic             inducer_on,
  output logic      [7:0]  inducer_cmd,
  output logic      [7:0]  mod_rate,
  output logic             spark_on,
  output logic             ign_module_on,
  output logic             safety_valve_open,
  output logic             gas_valve_open,
  output logic             stage_high,
  output logic             secondary_on
);
  localparam logic [1:0] LAST_TRIAL = 2'(`BIS_MAX_TRIALS - 1);

  bis_pkg::bis_state_e state_r, state_nxt;
  logic [1:0]  trials_r, trials_nxt;
  logic        open_ph_r, open_ph_nxt;
  logic        seen_r, seen_nxt;
  logic        restart_r, restart_nxt;
  logic [3:0]  ctrl_r;
  logic [7:0]  demand_r;
  logic        ack_r;
  logic        safe_ok;
  logic        call;
  logic [22:0] out_nxt, out_r;

  bis_tmr_if tif();

  bis_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .t    (tif.tmr)
  );

  assign call    = ctrl_r[`BIS_CTRL_CALL];
  assign safe_ok = hilimit_closed & rollout_closed;

  // bus slave: one wait cycle per access, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // register writes land on the edge where waitrequest is low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r   <= `BIS_CTRL_RST;
      demand_r <= `BIS_DEMAND_RST;
    end
    else if (avs_write && ack_r)
    begin
      if (avs_address == `BIS_CTRL_OFS)
        ctrl_r <= avs_writedata[3:0];
      else if (avs_address == `BIS_DEMAND_OFS)
        demand_r <= avs_writedata[7:0];
    end
  end

  // read data is captured in the wait cycle, so it stands at the answering edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_r)
    begin
      unique case (avs_address)
        `BIS_CTRL_OFS:    avs_readdata <= {28'h0, ctrl_r};
        `BIS_DEMAND_OFS:  avs_readdata <= {24'h0, demand_r};
        `BIS_STATUS_OFS:  avs_readdata <= {19'h0, open_ph_r, restart_r, flame, trials_r,
                                           state_r};
        `BIS_OUTPUTS_OFS: avs_readdata <= {9'h0, out_r};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // sequencer next state
  always_comb
  begin
    state_nxt   = state_r;
    trials_nxt  = trials_r;
    open_ph_nxt = open_ph_r;
    seen_nxt    = seen_r;
    restart_nxt = restart_r;
    unique case (state_r)
      bis_pkg::ST_OFF:
        if (call)
        begin
          state_nxt  = bis_pkg::ST_CHECK;
          trials_nxt = 2'b00;
        end
      bis_pkg::ST_CHECK:
        if (!call)
          state_nxt = bis_pkg::ST_OFF;
        else if (safe_ok && !airsw_closed && valve_pos_ok)
        begin
          state_nxt   = bis_pkg::ST_PURGE;
          open_ph_nxt = 1'b0;
          seen_nxt    = 1'b0;
          restart_nxt = 1'b0;
        end
      bis_pkg::ST_PURGE:
        if (!call || !safe_ok)
          state_nxt = bis_pkg::ST_POST;
        else if (!open_ph_r)
        begin
          // first phase: air switch must close under purge draft
          if (airsw_closed)
            seen_nxt = 1'b1;
          if (tif.done)
          begin
            if (seen_r || airsw_closed)
              open_ph_nxt = 1'b1;
            else
              state_nxt = bis_pkg::ST_OFF;
          end
        end
        else
        begin
          // second phase: inducer switched off, switch must open again
          if (!airsw_closed)
            state_nxt = bis_pkg::ST_IGNITE;
          else if (tif.done)
            state_nxt = bis_pkg::ST_OFF;
        end
      bis_pkg::ST_IGNITE:
        if (!call || !safe_ok)
          state_nxt = bis_pkg::ST_POST;
        else if (tif.done)
        begin
          // flame is judged only at trial end, the spark runs the full trial
          if (flame)
            state_nxt = bis_pkg::ST_WARMUP;
          else if (trials_r == LAST_TRIAL)
            state_nxt = bis_pkg::ST_LOCK;
          else
          begin
            state_nxt   = bis_pkg::ST_PURGE;
            trials_nxt  = trials_r + 2'b01;
            open_ph_nxt = 1'b0;
            seen_nxt    = 1'b0;
          end
        end
      bis_pkg::ST_WARMUP:
        if (!call || !safe_ok || !flame)
          state_nxt = bis_pkg::ST_POST;
        else if (tif.done)
          state_nxt = bis_pkg::ST_RUN;
      bis_pkg::ST_RUN:
        if (!call || !safe_ok || !airsw_closed || !flame)
          state_nxt = bis_pkg::ST_POST;
        else if (tif.done)
        begin
          state_nxt   = bis_pkg::ST_POST;
          restart_nxt = 1'b1;
        end
      bis_pkg::ST_POST:
        if (tif.done)
        begin
          restart_nxt = 1'b0;
          trials_nxt  = 2'b00;
          if (restart_r && call)
            state_nxt = bis_pkg::ST_CHECK;
          else
            state_nxt = bis_pkg::ST_OFF;
        end
      bis_pkg::ST_LOCK:
        if (tif.done)
          state_nxt = bis_pkg::ST_OFF;
      default:
        state_nxt = bis_pkg::ST_OFF;
    endcase
  end

  // state registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r   <= bis_pkg::ST_OFF;
      trials_r  <= 2'b00;
      open_ph_r <= 1'b0;
      seen_r    <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      trials_r  <= trials_nxt;
      open_ph_r <= open_ph_nxt;
      seen_r    <= seen_nxt;
      restart_r <= restart_nxt;
    end
  end

  // one shared timer, reloaded on every state entry and purge phase change
  assign tif.load = (state_nxt != state_r) || (open_ph_nxt && !open_ph_r);

  always_comb
  begin
    unique case (state_nxt)
      bis_pkg::ST_PURGE:  tif.secs = open_ph_nxt ? AIR_OPEN_S : PURGE_S;
      bis_pkg::ST_IGNITE: tif.secs = IGN_S;
      bis_pkg::ST_WARMUP: tif.secs = WARMUP_S;
      bis_pkg::ST_RUN:    tif.secs = MAX_RUN_S;
      bis_pkg::ST_POST:   tif.secs = POST_S;
      bis_pkg::ST_LOCK:   tif.secs = LOCKOUT_S;
      default:            tif.secs = 16'h0001;
    endcase
  end

  // output drive decoded from the next state so pins align with state_r
  always_comb
  begin
    logic staged;
    logic hi;
    staged  = ctrl_r[`BIS_CTRL_STAGED];
    hi      = ctrl_r[`BIS_CTRL_TWOSTG] ? (demand_r >= HIGH_THRESH) : 1'b1;
    out_nxt = 23'h0;
    unique case (state_nxt)
      bis_pkg::ST_PURGE:
        if (!open_ph_nxt)
        begin
          out_nxt[22]    = 1'b1;
          out_nxt[15:8]  = PURGE_SET;
        end
      bis_pkg::ST_IGNITE, bis_pkg::ST_WARMUP:
      begin
        out_nxt[22]    = 1'b1;
        out_nxt[15:8]  = LIGHT_IND;
        out_nxt[7:0]   = staged ? 8'h00 : LIGHT_RATE;
        out_nxt[16]    = (state_nxt == bis_pkg::ST_IGNITE);
        out_nxt[17]    = (state_nxt == bis_pkg::ST_IGNITE);
        out_nxt[18]    = 1'b1;
        out_nxt[19]    = staged;
      end
      bis_pkg::ST_RUN:
      begin
        out_nxt[22]    = 1'b1;
        out_nxt[18]    = 1'b1;
        out_nxt[21]    = ctrl_r[`BIS_CTRL_SPLIT] && (demand_r >= SEC_THRESH);
        if (staged)
        begin
          out_nxt[19]   = 1'b1;
          out_nxt[20]   = hi;
          out_nxt[15:8] = LIGHT_IND;
        end
        else
        begin
          out_nxt[7:0]  = demand_r;
          out_nxt[15:8] = demand_r;
        end
      end
      bis_pkg::ST_POST:
      begin
        out_nxt[22]    = 1'b1;
        out_nxt[15:8]  = LIGHT_IND;
        out_nxt[7:0]   = staged ? 8'h00 : VALVE_SET;
      end
      default:
        out_nxt = 23'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_r <= 23'h0;
    else
      out_r <= out_nxt;
  end

  assign mod_rate          = out_r[7:0];
  assign inducer_cmd       = out_r[15:8];
  assign spark_on          = out_r[16];
  assign ign_module_on     = out_r[17];
  assign safety_valve_open = out_r[18];
  assign gas_valve_open    = out_r[19];
  assign stage_high        = out_r[20];
  assign secondary_on      = out_r[21];
  assign inducer_on        = out_r[22];

  // checks on the sequencer
  AST_CHECK_NEEDS_CALL: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_CHECK) && ($past(state_r) != bis_pkg::ST_CHECK) |-> $past(call))
    else $error("check entered without call for heat");

  AST_PURGE_GUARD: assert property (@(posedge clk) disable iff (!rstn)
    ($past(state_r) == bis_pkg::ST_CHECK) && (state_r == bis_pkg::ST_PURGE)
      |-> $past(safe_ok && !airsw_closed && valve_pos_ok))
    else $error("purge entered with a failed system check");

  AST_PURGE_DRAFT: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_PURGE) && !open_ph_r |-> inducer_on && inducer_cmd == PURGE_SET)
    else $error("purge without purge draft");

  AST_TRIAL_SPARK: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_IGNITE) |-> spark_on && ign_module_on && safety_valve_open
      && inducer_cmd == LIGHT_IND)
    else $error("spark or valve dropped during trial");

  AST_LOCK_AFTER_THREE: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_LOCK) && ($past(state_r) != bis_pkg::ST_LOCK)
      |-> $past(trials_r) == LAST_TRIAL && !$past(flame))
    else $error("lockout without three failed trials");

  AST_RUN_AFTER_WARMUP: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_RUN) && ($past(state_r) != bis_pkg::ST_RUN)
      |-> $past(state_r) == bis_pkg::ST_WARMUP)
    else $error("run entered without warmup");

  AST_RUN_RATE: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_RUN) && !ctrl_r[`BIS_CTRL_STAGED] ##1 (state_r == bis_pkg::ST_RUN)
      |-> mod_rate == $past(demand_r) && inducer_cmd == $past(demand_r))
    else $error("firing rate does not follow demand");

  AST_RUN_TRIP: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_RUN) && (!call || !safe_ok) |=> state_r == bis_pkg::ST_POST
      && !safety_valve_open && !gas_valve_open)
    else $error("run did not end on trip or lost call");

  AST_POST_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_POST) |-> !safety_valve_open && inducer_on
      && inducer_cmd == LIGHT_IND && !spark_on)
    else $error("post-purge drive wrong");

  AST_OFF_QUIET: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == bis_pkg::ST_OFF) |-> out_r == 23'h0)
    else $error("output energized in off state");
endmodule

// [test/bis_plant.sv]
// furnace plant model: combustion air switch and flame sensor seen by the sequencer
// assumes the bench sets no_light and air_mode between heating cycles only
module bis_plant (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       inducer_on,
  input  wire logic       safety_valve_open,
  input  wire logic       no_light,
  input  wire logic [1:0] air_mode,
  output logic            airsw_closed,
  output logic            flame
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] draft_r;
  logic [1:0] fire_r;

  // draft and flame lag their causes by two cycles, so nothing is proven instantly
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      draft_r <= 2'b00;
      fire_r  <= 2'b00;
    end
    else
    begin
      draft_r <= {draft_r[0], inducer_on};
      fire_r  <= {fire_r[0], safety_valve_open & ~no_light};
    end
  end

  // mode 1 sticks the switch open, mode 2 sticks it closed
  assign airsw_closed = (air_mode == 2'd2) | (draft_r[1] & (air_mode == 2'd0));
  assign flame        = fire_r[1];
endmodule

// [test/burner_ignition_sequencer_test.sv]
// self-checking bench: register bus tasks, output model per state, plant on the pins
// assumes bis_pkg, bis_tmr_if, bis_timer, bis_top and bis_plant compiled before it
`include "bis_regs.svh"
module burner_ignition_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  logic        hilimit_closed = 1'b1;
  logic        rollout_closed = 1'b1;
  logic        valve_pos_ok = 1'b1;
  logic        no_light = 1'b0;
  logic [1:0]  air_mode = 2'd0;
  wire         airsw_closed, flame, inducer_on, spark_on, ign_module_on;
  wire  [7:0]  inducer_cmd, mod_rate;
  wire         safety_valve_open, gas_valve_open, stage_high, secondary_on;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] rnd = 32'h3ce03059;
  logic [31:0] q;

  always #25 clk = ~clk;

  // shortened timers keep the run short: one tick is four clocks; trial, air-open and
  // post-purge keep their default tick counts, so those defaults run as well
  bis_top #(.TICK_CYCLES(4), .PURGE_S(16'h0003), .WARMUP_S(16'h0003),
    .LOCKOUT_S(16'h0004), .MAX_RUN_S(16'h0006)) i_dut (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hilimit_closed(hilimit_closed),
    .rollout_closed(rollout_closed), .airsw_closed(airsw_closed),
    .valve_pos_ok(valve_pos_ok), .flame(flame), .inducer_on(inducer_on),
    .inducer_cmd(inducer_cmd), .mod_rate(mod_rate), .spark_on(spark_on),
    .ign_module_on(ign_module_on), .safety_valve_open(safety_valve_open),
    .gas_valve_open(gas_valve_open), .stage_high(stage_high), .secondary_on(secondary_on));

  bis_plant i_plant (.clk(clk), .rstn(rstn), .inducer_on(inducer_on),
    .safety_valve_open(safety_valve_open), .no_light(no_light), .air_mode(air_mode),
    .airsw_closed(airsw_closed), .flame(flame));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one transfer; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge clk);
    // no cycle count assumed: only the bench timeout ends a stuck wait
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  function automatic logic [31:0] pins();
    return {9'h0, inducer_on, secondary_on, stage_high, gas_valve_open, safety_valve_open,
            ign_module_on, spark_on, inducer_cmd, mod_rate};
  endfunction

  // expected output word per state, variant bits and demand
  function automatic logic [31:0] exp_out(input logic [7:0] s, input logic [3:0] c,
                                          input logic [7:0] d);
    logic [31:0] e;
    e = 32'h0;
    if (s != bis_pkg::ST_OFF && s != bis_pkg::ST_CHECK && s != bis_pkg::ST_LOCK)
      e[22] = 1'b1;
    if (s == bis_pkg::ST_PURGE)
      e[15:8] = 8'hc0;
    if (s == bis_pkg::ST_IGNITE || s == bis_pkg::ST_WARMUP || s == bis_pkg::ST_POST)
      e[15:8] = 8'h80;
    if (s == bis_pkg::ST_IGNITE || s == bis_pkg::ST_WARMUP || s == bis_pkg::ST_RUN)
    begin
      e[18] = 1'b1;
      e[19] = c[1];
      e[7:0] = c[1] ? 8'h00 : 8'h40;
    end
    if (s == bis_pkg::ST_IGNITE)
      e[17:16] = 2'b11;
    if (s == bis_pkg::ST_RUN)
    begin
      e[21] = c[2] && d >= 8'h80;
      e[20] = c[1] && (!c[3] || d >= 8'hf0);
      e[15:8] = c[1] ? 8'h80 : d;
      e[7:0] = c[1] ? 8'h00 : d;
    end
    return e;
  endfunction

  // poll status until state s, then compare register and pins with the model
  task automatic wait_st(input logic [7:0] s, input logic [3:0] c, input logic [7:0] d,
                         output logic [31:0] st);
    int n;
    logic [31:0] o;
    n = 0;
    st = 32'h0;
    while (st[7:0] !== s && n < 100)
    begin
      rd(`BIS_STATUS_OFS, st);
      n++;
    end
    rd(`BIS_OUTPUTS_OFS, o);
    chk({24'h0, st[7:0]}, {24'h0, s}, "state");
    chk(o, exp_out(s, c, d), "outputs register");
    chk(pins(), exp_out(s, c, d), "output pins");
  endtask

  // one heating cycle, ended by call drop (0), rollout trip (1) or run limit (2)
  task automatic seq(input logic [3:0] c, input logic [7:0] d, input int stop);
    wr(`BIS_DEMAND_OFS, {24'h0, d});
    wr(`BIS_CTRL_OFS, {28'h0, c | 4'h1});
    wait_st(bis_pkg::ST_PURGE, c, d, q);
    wait_st(bis_pkg::ST_IGNITE, c, d, q);
    chk({30'h0, flame, spark_on}, 32'h3, "spark with flame");
    wait_st(bis_pkg::ST_WARMUP, c, d, q);
    wait_st(bis_pkg::ST_RUN, c, d, q);
    if (stop == 1)
      rollout_closed <= 1'b0;
    else if (stop == 0)
      wr(`BIS_CTRL_OFS, {28'h0, c});
    wait_st(bis_pkg::ST_POST, c, d, q);
    chk({31'h0, q[11]}, {31'h0, stop == 2}, "restart pending");
    if (stop == 2)
      wait_st(bis_pkg::ST_PURGE, c, d, q);
    wr(`BIS_CTRL_OFS, {28'h0, c});
    rollout_closed <= 1'b1;
    wait_st(bis_pkg::ST_OFF, c, d, q);
  endtask

  // hang guard, far above the few thousand cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      failures++;
      print_verdict();
    end
  end

  initial
  begin
    int n;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // unmapped and read-only writes must leave everything idle
    wr(4'h1, 32'hffffffff);
    wr(`BIS_STATUS_OFS, 32'hffffffff);
    rd(`BIS_CTRL_OFS, q);
    chk(q, 32'h0, "control");
    rd(`BIS_DEMAND_OFS, q);
    chk(q, 32'h0, "demand");
    rd(4'h1, q);
    chk(q, 32'h0, "unmapped");
    repeat (20) @(posedge clk);
    wait_st(bis_pkg::ST_OFF, 4'h0, 8'h0, q);
    // each failed precondition holds the board in check
    for (int i = 0; i < 4; i++)
    begin
      hilimit_closed <= (i != 0);
      rollout_closed <= (i != 1);
      air_mode <= (i == 2) ? 2'd2 : 2'd0;
      valve_pos_ok <= (i != 3);
      wr(`BIS_CTRL_OFS, 32'h1);
      repeat (30) @(posedge clk);
      wait_st(bis_pkg::ST_CHECK, 4'h1, 8'h0, q);
      wr(`BIS_CTRL_OFS, 32'h0);
      wait_st(bis_pkg::ST_OFF, 4'h0, 8'h0, q);
    end
    hilimit_closed <= 1'b1;
    rollout_closed <= 1'b1;
    air_mode <= 2'd0;
    valve_pos_ok <= 1'b1;
    rnd = lfsr(rnd);
    seq(4'h0, rnd[7:0] | 8'h01, 0);
    seq(4'h4, 8'h80, 1);
    seq(4'h4, 8'h7f, 2);
    seq(4'ha, 8'hf0, 0);
    seq(4'ha, 8'hef, 1);
    rnd = lfsr(rnd);
    seq(4'h6, rnd[7:0] | 8'h01, 0);
    // three trials without flame, then lockout that expires to off
    no_light <= 1'b1;
    wr(`BIS_CTRL_OFS, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      wait_st(bis_pkg::ST_PURGE, 4'h0, 8'h0, q);
      wait_st(bis_pkg::ST_IGNITE, 4'h0, 8'h0, q);
      chk({30'h0, q[9:8]}, 32'(i), "failed trials");
    end
    wait_st(bis_pkg::ST_LOCK, 4'h0, 8'h0, q);
    wr(`BIS_CTRL_OFS, 32'h0);
    wait_st(bis_pkg::ST_OFF, 4'h0, 8'h0, q);
    no_light <= 1'b0;
    // air switch never proving: gas must stay shut
    air_mode <= 2'd1;
    wr(`BIS_CTRL_OFS, 32'h1);
    wait_st(bis_pkg::ST_PURGE, 4'h0, 8'h0, q);
    n = 0;
    repeat (60)
    begin
      @(posedge clk);
      if (safety_valve_open !== 1'b0)
        n++;
    end
    chk(32'(n), 32'h0, "gas without air proof");
    wr(`BIS_CTRL_OFS, 32'h0);
    air_mode <= 2'd0;
    wait_st(bis_pkg::ST_OFF, 4'h0, 8'h0, q);
    print_verdict();
  end
endmodule
